//--- pkg/clk_ctrl_regs.svh
// Summary of operation
// - clocks come from a 2-stage prescaler then a 21-stage divider chain
// - prescaler and divider clear on reset and on stop entry and release
// - slow and sleep modes feed the slow clock into stage seven directly
// - warm-up after stop from a run mode feeds stage six into stage seven
// - a machine cycle is four states, each one main clock period
// - instructions take one to ten machine cycles on the main clock
// - single-clock mode runs fast clock only; slow pins are ports
// - reset starts in run_single with core and peripherals on fast clock
// - idle bit enters doze_single: cpu and watchdog halt, peripherals run
// - doze_single returns to run_single on any interrupt request
// - doze wake services interrupt if master enable, else resumes next
// - generator_halt enters deep doze; only time-base timer keeps clock
// - falling edge of selected time-base source ends deep doze
// - deep doze entry and exit ignore time_base_enable
// - time-base interrupt taken only when all three enables are one
// - deep doze entered with time_base_enable sets pending latch on return
// - dual mode runs both oscillators; main clock fast or slow by mode
// - slow and sleep machine cycle is four slow clock periods
// - sysclk_sel one goes run_dual to slow_both_osc, zero goes back
// - clearing fast_osc_enable in slow_both_osc stops fast oscillator, to slow_osc_only
// - after stop wake, execution resumes only once warm-up completes
`ifndef CLK_CTRL_REGS_SVH
`define CLK_CTRL_REGS_SVH

`define ADDR_SYS_CTRL_FIRST   4'h0
`define ADDR_SYS_CTRL_SECOND  4'h1
`define ADDR_TIME_BASE_CTRL   4'h2
`define ADDR_MODE_STATUS      4'h3

// sys_ctrl_first
`define SC1_STOP_BIT          7
// sys_ctrl_second
`define SC2_FAST_OSC_BIT      7
`define SC2_SLOW_OSC_BIT      6
`define SC2_SYSCLK_SEL_BIT    5
`define SC2_GEN_HALT_BIT      4
`define SC2_IDLE_BIT          3
// time_base_ctrl
`define TBC_TB_ENABLE_BIT     7
`define TBC_STAGE7_SEL_BIT    4
`define TBC_TB_SRC_LSB        0

`define RST_SYS_CTRL_SECOND   8'h80
`define RST_TIME_BASE_CTRL    8'h00

`define PRESCALE_STAGES       2
`define DIVIDER_STAGES        21
`define LOW_STAGES            8
`define STATES_PER_MCYCLE     4
`define MAX_INSTR_MCYCLES     4'hA
`define WARMUP_DIV_BIT        12
`endif

//--- pkg/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
  typedef enum logic [3:0] {
    RUN_SINGLE       = 4'h0,
    DOZE_SINGLE      = 4'h1,
    DEEP_DOZE_SINGLE = 4'h3,
    RUN_DUAL         = 4'h2,
    DOZE_DUAL        = 4'h6,
    SLOW_BOTH_OSC    = 4'h7,
    SLOW_OSC_ONLY    = 4'h5,
    SLEEP_SLOW_ONLY  = 4'h4,
    SLEEP_BOTH_OSC   = 4'hC,
    DEEP_SLEEP_SLOW  = 4'hD,
    STOP_HALT        = 4'hF,
    STOP_WARMUP      = 4'hE
  } op_mode_t;

  typedef logic [1:0] mc_state_t;
endpackage : clk_ctrl_pkg

//--- rtl/system_clock_mode_controller.sv
`timescale 1ns/1ns
`include "clk_ctrl_regs.svh"
module system_clock_mode_controller (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_resetn,
  input  wire logic [3:0]            i_addr,
  input  wire logic [7:0]            i_wr_data,
  input  wire logic                  i_wr_en,
  input  wire logic                  i_rd_en,
  input  wire logic                  i_slow_xtal_in,
  input  wire logic                  i_stop_wake_n,
  input  wire logic                  i_irq_req,
  input  wire logic                  i_int_master_enable,
  input  wire logic                  i_time_base_irq_en,
  input  wire logic                  i_time_base_irq_clr,
  input  wire logic [3:0]            i_instr_mcycles,
  input  wire logic                  i_instr_start,
  output logic [7:0]                 o_rd_data,
  output clk_ctrl_pkg::op_mode_t     o_mode,
  output clk_ctrl_pkg::mc_state_t    o_mc_state,
  output logic                       o_main_tick,
  output logic                       o_mcycle_end,
  output logic                       o_instr_done,
  output logic [20:0]                o_divider,
  output logic                       o_cpu_run,
  output logic                       o_wdt_run,
  output logic                       o_periph_clk_en,
  output logic                       o_tbt_clk_en,
  output logic                       o_fast_osc_on,
  output logic                       o_slow_osc_on,
  output logic                       o_slow_pins_are_port,
  output logic                       o_main_from_slow,
  output logic                       o_irq_accept,
  output logic                       o_resume_next,
  output logic                       o_time_base_irq,
  output logic                       o_time_base_irq_take
);
  import clk_ctrl_pkg::*;

  function automatic logic tb_tap(input logic [2:0] sel,
                                  input logic [20:0] dv);
    // source taps spread along the upper divider stages
    unique case (sel)
      3'h0: tb_tap = dv[20];
      3'h1: tb_tap = dv[18];
      3'h2: tb_tap = dv[16];
      3'h3: tb_tap = dv[14];
      3'h4: tb_tap = dv[12];
      3'h5: tb_tap = dv[11];
      3'h6: tb_tap = dv[10];
      3'h7: tb_tap = dv[8];
    endcase
  endfunction : tb_tap

  function automatic logic is_slow_mode(input op_mode_t m);
    is_slow_mode = (m == SLOW_BOTH_OSC) || (m == SLOW_OSC_ONLY) ||
                   (m == SLEEP_SLOW_ONLY) || (m == SLEEP_BOTH_OSC) ||
                   (m == DEEP_SLEEP_SLOW);
  endfunction : is_slow_mode

  // pin synchronisers
  logic       slow_s1_q;
  logic       slow_s2_q;
  logic       slow_s3_q;
  logic       wake_s1_q;
  logic       wake_s2_q;

  // software state
  logic       stop_req_q;
  logic       fast_osc_enable_q;
  logic       slow_osc_enable_q;
  logic       sysclk_sel_q;
  logic       generator_halt_q;
  logic       idle_req_q;
  logic       time_base_enable_q;
  logic       stage7_src_sel_q;
  logic [2:0] time_base_src_q;

  op_mode_t   mode_q;
  op_mode_t   mode_d;
  op_mode_t   resume_mode_q;
  logic       warm_from_run_q;
  logic       tb_en_at_entry_q;
  logic [1:0] pre_q;
  logic [20:0] div_q;
  logic [20:0] div_d;
  logic [1:0] pre_d;
  logic       tb_prev_q;
  logic [1:0] state_q;
  logic [3:0] instr_cnt_q;
  logic       tb_pend_q;

  // decode
  wire        wr_sc1  = i_wr_en && (i_addr == `ADDR_SYS_CTRL_FIRST);
  wire        wr_sc2  = i_wr_en && (i_addr == `ADDR_SYS_CTRL_SECOND);
  wire        wr_tbc  = i_wr_en && (i_addr == `ADDR_TIME_BASE_CTRL);
  wire        slow_tick = slow_s2_q && !slow_s3_q;
  wire        slow_mode = is_slow_mode(mode_q);
  wire        stop_like = (mode_q == STOP_HALT) || (mode_q == STOP_WARMUP);
  wire        fast_running = !stop_like &&
                             (mode_q != SLOW_OSC_ONLY) &&
                             (mode_q != SLEEP_SLOW_ONLY) &&
                             (mode_q != DEEP_SLEEP_SLOW);
  wire        warm_run  = (mode_q == STOP_WARMUP) && warm_from_run_q;
  // a stop taken from a slow mode warms up on the slow clock
  wire        warm_slow = (mode_q == STOP_WARMUP) && !warm_from_run_q;
  // stages 1..6 only count while the fast oscillator feeds them
  wire        low_carry = (fast_running || warm_run) &&
                          (&pre_q) && (&div_q[5:0]);
  wire        dual_fast = (mode_q == RUN_DUAL) || (mode_q == DOZE_DUAL);
  wire        stage7_in =
      warm_run            ? low_carry :
      warm_slow           ? slow_tick :
      slow_mode           ? slow_tick :
      dual_fast           ? (stage7_src_sel_q ? slow_tick
                                              : low_carry) :
                            low_carry;
  wire        tb_src    = tb_tap(time_base_src_q, div_q);
  wire        tb_fall   = tb_prev_q && !tb_src;
  wire        warm_done = (mode_q == STOP_WARMUP) &&
                          div_q[`WARMUP_DIV_BIT];
  wire        main_tick = slow_mode ? slow_tick
                                    : fast_running;
  wire        cpu_run   = (mode_q == RUN_SINGLE) ||
                          (mode_q == RUN_DUAL) ||
                          (mode_q == SLOW_BOTH_OSC) ||
                          (mode_q == SLOW_OSC_ONLY);
  wire        deep_mode = (mode_q == DEEP_DOZE_SINGLE) ||
                          (mode_q == DEEP_SLEEP_SLOW);
  wire        doze_mode = (mode_q == DOZE_SINGLE) ||
                          (mode_q == DOZE_DUAL) ||
                          (mode_q == SLEEP_SLOW_ONLY) ||
                          (mode_q == SLEEP_BOTH_OSC);
  wire        doze_wake = doze_mode && i_irq_req;
  wire        deep_wake = deep_mode && tb_fall;
  wire        stop_enter = cpu_run && stop_req_q;
  // clearing on both stop edges keeps warm-up length independent of history
  wire        div_clear = stop_enter ||
                          ((mode_q == STOP_HALT) && !wake_s2_q);
  wire        mc_end    = main_tick && (state_q == 2'h3);
  wire        tb_set    = (deep_wake && tb_en_at_entry_q) ||
                          (!deep_mode && cpu_run && tb_fall &&
                           time_base_enable_q);
  wire [7:0]  sc1_view  = {stop_req_q, 7'h00};
  wire [7:0]  sc2_view  = {fast_osc_enable_q, slow_osc_enable_q,
                           sysclk_sel_q, generator_halt_q,
                           idle_req_q, 3'h0};
  wire [7:0]  tbc_view  = {time_base_enable_q, 2'h0, stage7_src_sel_q,
                           1'b0, time_base_src_q};
  wire [7:0]  stat_view = {tb_pend_q, state_q, 1'b0, mode_q};
  wire [7:0]  rd_mux    =
      !i_rd_en                          ? 8'h00 :
      (i_addr == `ADDR_SYS_CTRL_FIRST)  ? sc1_view :
      (i_addr == `ADDR_SYS_CTRL_SECOND) ? sc2_view :
      (i_addr == `ADDR_TIME_BASE_CTRL)  ? tbc_view :
      (i_addr == `ADDR_MODE_STATUS)     ? stat_view : 8'h00;

  // divider next value
  always_comb begin
    pre_d = pre_q;
    div_d = div_q;
    if (div_clear || warm_done) begin
      pre_d = 2'h0;
      div_d = 21'h0;
    end else begin
      if (fast_running || (mode_q == STOP_WARMUP && warm_from_run_q)) begin
        pre_d = pre_q + 2'h1;
        if (&pre_q) begin
          div_d[5:0] = div_q[5:0] + 6'h01;
        end
      end
      if (stage7_in) begin
        div_d[20:6] = div_q[20:6] + 15'h0001;
      end
    end
  end

  // mode sequencer
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      RUN_SINGLE: begin
        if (stop_req_q) begin
          mode_d = STOP_HALT;
        end else if (generator_halt_q) begin
          mode_d = DEEP_DOZE_SINGLE;
        end else if (idle_req_q) begin
          mode_d = DOZE_SINGLE;
        end else if (slow_osc_enable_q) begin
          mode_d = RUN_DUAL;
        end
      end
      DOZE_SINGLE: begin
        if (doze_wake) begin
          mode_d = RUN_SINGLE;
        end
      end
      DEEP_DOZE_SINGLE: begin
        if (deep_wake) begin
          mode_d = RUN_SINGLE;
        end
      end
      RUN_DUAL: begin
        if (stop_req_q) begin
          mode_d = STOP_HALT;
        end else if (idle_req_q) begin
          mode_d = DOZE_DUAL;
        end else if (sysclk_sel_q) begin
          mode_d = SLOW_BOTH_OSC;
        end else if (!slow_osc_enable_q) begin
          mode_d = RUN_SINGLE;
        end
      end
      DOZE_DUAL: begin
        if (doze_wake) begin
          mode_d = RUN_DUAL;
        end
      end
      SLOW_BOTH_OSC: begin
        if (stop_req_q) begin
          mode_d = STOP_HALT;
        end else if (generator_halt_q) begin
          mode_d = DEEP_SLEEP_SLOW;
        end else if (idle_req_q) begin
          mode_d = SLEEP_BOTH_OSC;
        end else if (!sysclk_sel_q) begin
          mode_d = RUN_DUAL;
        end else if (!fast_osc_enable_q) begin
          mode_d = SLOW_OSC_ONLY;
        end
      end
      SLOW_OSC_ONLY: begin
        if (stop_req_q) begin
          mode_d = STOP_HALT;
        end else if (generator_halt_q) begin
          mode_d = DEEP_SLEEP_SLOW;
        end else if (idle_req_q) begin
          mode_d = SLEEP_SLOW_ONLY;
        end else if (fast_osc_enable_q) begin
          mode_d = SLOW_BOTH_OSC;
        end
      end
      SLEEP_SLOW_ONLY: begin
        if (doze_wake) begin
          mode_d = SLOW_OSC_ONLY;
        end
      end
      SLEEP_BOTH_OSC: begin
        if (doze_wake) begin
          mode_d = SLOW_BOTH_OSC;
        end
      end
      DEEP_SLEEP_SLOW: begin
        if (deep_wake) begin
          mode_d = SLOW_OSC_ONLY;
        end
      end
      STOP_HALT: begin
        if (!wake_s2_q) begin
          mode_d = STOP_WARMUP;
        end
      end
      STOP_WARMUP: begin
        if (warm_done) begin
          mode_d = resume_mode_q;
        end
      end
      default: mode_d = RUN_SINGLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
      wake_s1_q <= 1'b1;
      wake_s2_q <= 1'b1;
    end else begin
      slow_s1_q <= i_slow_xtal_in;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
      wake_s1_q <= i_stop_wake_n;
      wake_s2_q <= wake_s1_q;
    end
  end

  // idle, halt and stop requests clear themselves once the mode is taken
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_req_q         <= 1'b0;
      fast_osc_enable_q  <= 1'b1;
      slow_osc_enable_q  <= 1'b0;
      sysclk_sel_q       <= 1'b0;
      generator_halt_q   <= 1'b0;
      idle_req_q         <= 1'b0;
      time_base_enable_q <= 1'b0;
      stage7_src_sel_q   <= 1'b0;
      time_base_src_q    <= 3'h0;
    end else begin
      stop_req_q       <= wr_sc1 ? i_wr_data[`SC1_STOP_BIT]
                                 : (stop_req_q && !stop_enter);
      generator_halt_q <= wr_sc2 ? i_wr_data[`SC2_GEN_HALT_BIT]
                                 : (generator_halt_q && cpu_run);
      idle_req_q       <= wr_sc2 ? i_wr_data[`SC2_IDLE_BIT]
                                 : (idle_req_q && cpu_run);
      if (wr_sc2) begin
        fast_osc_enable_q <= i_wr_data[`SC2_FAST_OSC_BIT];
        slow_osc_enable_q <= i_wr_data[`SC2_SLOW_OSC_BIT];
        sysclk_sel_q      <= i_wr_data[`SC2_SYSCLK_SEL_BIT];
      end
      if (wr_tbc) begin
        time_base_enable_q <= i_wr_data[`TBC_TB_ENABLE_BIT];
        stage7_src_sel_q   <= i_wr_data[`TBC_STAGE7_SEL_BIT];
        time_base_src_q    <= i_wr_data[`TBC_TB_SRC_LSB +: 3];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q           <= RUN_SINGLE;
      resume_mode_q    <= RUN_SINGLE;
      warm_from_run_q  <= 1'b0;
      tb_en_at_entry_q <= 1'b0;
      pre_q            <= 2'h0;
      div_q            <= 21'h0;
      tb_prev_q        <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      pre_q     <= pre_d;
      div_q     <= div_d;
      tb_prev_q <= tb_src;
      if (stop_enter) begin
        resume_mode_q   <= mode_q;
        warm_from_run_q <= !slow_mode;
      end
      if (cpu_run && (mode_d != mode_q)) begin
        tb_en_at_entry_q <= time_base_enable_q;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q     <= 2'h0;
      instr_cnt_q <= 4'h0;
      tb_pend_q   <= 1'b0;
    end else begin
      if (main_tick) begin
        state_q <= state_q + 2'h1;
      end
      if (i_instr_start && cpu_run) begin
        instr_cnt_q <= (i_instr_mcycles == 4'h0) ? 4'h1 :
                       (i_instr_mcycles > `MAX_INSTR_MCYCLES) ?
                       `MAX_INSTR_MCYCLES : i_instr_mcycles;
      end else if (mc_end && cpu_run && (instr_cnt_q != 4'h0)) begin
        instr_cnt_q <= instr_cnt_q - 4'h1;
      end
      // a set in the same cycle as the clear wins
      tb_pend_q <= tb_set || (tb_pend_q && !i_time_base_irq_clr);
    end
  end

  // registered outputs
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data            <= 8'h00;
      o_mode               <= RUN_SINGLE;
      o_mc_state           <= 2'h0;
      o_main_tick          <= 1'b0;
      o_mcycle_end         <= 1'b0;
      o_instr_done         <= 1'b0;
      o_divider            <= 21'h0;
      o_cpu_run            <= 1'b1;
      o_wdt_run            <= 1'b1;
      o_periph_clk_en      <= 1'b1;
      o_tbt_clk_en         <= 1'b1;
      o_fast_osc_on        <= 1'b1;
      o_slow_osc_on        <= 1'b0;
      o_slow_pins_are_port <= 1'b1;
      o_main_from_slow     <= 1'b0;
      o_irq_accept         <= 1'b0;
      o_resume_next        <= 1'b0;
      o_time_base_irq      <= 1'b0;
      o_time_base_irq_take <= 1'b0;
    end else begin
      o_rd_data            <= rd_mux;
      o_mode               <= mode_d;
      o_mc_state           <= state_q;
      o_main_tick          <= main_tick;
      o_mcycle_end         <= mc_end;
      o_instr_done         <= mc_end && cpu_run && (instr_cnt_q == 4'h1);
      o_divider            <= div_q;
      o_cpu_run            <= cpu_run;
      o_wdt_run            <= cpu_run;
      o_periph_clk_en      <= !deep_mode && !stop_like;
      o_tbt_clk_en         <= !stop_like;
      o_fast_osc_on        <= fast_running;
      o_slow_osc_on        <= slow_osc_enable_q;
      o_slow_pins_are_port <= !slow_osc_enable_q;
      o_main_from_slow     <= slow_mode;
      o_irq_accept         <= doze_wake && i_int_master_enable;
      o_resume_next        <= (doze_wake && !i_int_master_enable) ||
                              warm_done;
      o_time_base_irq      <= tb_pend_q;
      o_time_base_irq_take <= tb_pend_q && i_int_master_enable &&
                              i_time_base_irq_en && time_base_enable_q;
    end
  end
endmodule : system_clock_mode_controller

//--- bench/clk_ctrl_asserts.sv
`timescale 1ns/1ns
module clk_ctrl_asserts (
  input logic                   i_core_clk,
  input logic                   i_resetn,
  input logic                   i_irq_req,
  input logic                   i_int_master_enable,
  input clk_ctrl_pkg::op_mode_t o_mode,
  input logic                   o_main_tick,
  input logic                   o_mcycle_end,
  input logic                   o_instr_done,
  input logic [20:0]            o_divider,
  input logic                   o_cpu_run,
  input logic                   o_wdt_run,
  input logic                   o_periph_clk_en,
  input logic                   o_tbt_clk_en,
  input logic                   o_slow_osc_on,
  input logic                   o_slow_pins_are_port,
  input logic                   o_main_from_slow,
  input logic                   o_irq_accept,
  input logic                   o_resume_next
);
  import clk_ctrl_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  op_mode_t   prev_q;
  logic [2:0] tick_q;
  logic       valid_q;
  logic       stay;
  logic       slow_m;
  logic       stop_m;
  assign stay   = (o_mode == prev_q);
  assign stop_m = o_mode inside {STOP_HALT, STOP_WARMUP};
  assign slow_m = o_mode inside {SLOW_BOTH_OSC, SLOW_OSC_ONLY,
                                 SLEEP_SLOW_ONLY, SLEEP_BOTH_OSC};
  // first machine cycle after reset or stop may start mid-count
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q  <= RUN_SINGLE;
      tick_q  <= 3'h0;
      valid_q <= 1'b0;
    end else begin
      prev_q  <= o_mode;
      tick_q  <= (o_mcycle_end || stop_m) ? 3'h0 : tick_q + 3'(o_main_tick);
      valid_q <= !stop_m && (valid_q || o_mcycle_end);
    end
  end
  a_mcycle_four: assert property (o_mcycle_end && valid_q |->
    o_main_tick && tick_q == 3'h3) else $error("mcycle not 4 states");
  a_single_fast: assert property (stay && o_mode == RUN_SINGLE |->
    o_slow_pins_are_port && !o_main_from_slow) else $error("single clk");
  a_doze_halts: assert property (stay && o_mode == DOZE_SINGLE |->
    !o_cpu_run && !o_wdt_run && o_periph_clk_en) else $error("doze");
  a_doze_wake: assert property (o_mode == DOZE_SINGLE && i_irq_req |=>
    o_mode == RUN_SINGLE && o_irq_accept == $past(i_int_master_enable)
    && o_resume_next != $past(i_int_master_enable)) else $error("wake");
  a_deep_gate: assert property (stay && o_mode == DEEP_DOZE_SINGLE |->
    !o_periph_clk_en && o_tbt_clk_en) else $error("deep doze gate");
  a_dual_pins: assert property (stay && o_mode == RUN_DUAL |->
    !o_slow_pins_are_port && o_slow_osc_on && !o_main_from_slow)
    else $error("dual mode");
  a_slow_main: assert property (stay && slow_m |->
    o_main_from_slow && o_slow_osc_on) else $error("slow main clk");
  a_stop_clear: assert property (stay && o_mode == STOP_HALT |->
    o_divider == 21'h0) else $error("divider not clear");
  a_done_on_end: assert property (o_instr_done |->
    o_mcycle_end) else $error("instr done off mcycle end");
  c_doze_wake: cover property (o_mode == DOZE_SINGLE && i_irq_req);
  c_deep_exit: cover property (prev_q == DEEP_DOZE_SINGLE && !stay);
  c_stop_done: cover property (prev_q == STOP_WARMUP && !stay);
endmodule : clk_ctrl_asserts

bind system_clock_mode_controller clk_ctrl_asserts u_chk (.i_core_clk,
  .i_resetn, .i_irq_req, .i_int_master_enable, .o_mode, .o_main_tick,
  .o_mcycle_end, .o_instr_done, .o_divider, .o_cpu_run, .o_wdt_run,
  .o_periph_clk_en,
  .o_tbt_clk_en, .o_slow_osc_on, .o_slow_pins_are_port, .o_main_from_slow,
  .o_irq_accept, .o_resume_next);

//--- bench/clk_partner.sv
`timescale 1ns/1ns
module clk_partner #(
  parameter int SLOW_HALF = 20
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_resetn,
  input  wire logic  i_cpu_run,
  input  wire logic  i_instr_done,
  output logic       o_slow_xtal,
  output logic [3:0] o_mcycles,
  output logic       o_start
);
  int   half_q;
  logic busy_q;
  // exact slow period keeps machine cycle timing checkable in core cycles
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      half_q <= 0;
      o_slow_xtal <= 1'b0;
      busy_q <= 1'b0;
      o_start <= 1'b0;
      o_mcycles <= 4'h1;
    end else begin
      half_q <= (half_q == SLOW_HALF - 1) ? 0 : half_q + 1;
      if (half_q == SLOW_HALF - 1) o_slow_xtal <= ~o_slow_xtal;
      o_start <= i_cpu_run && !busy_q && !o_start;
      if (o_start) busy_q <= 1'b1;
      else if (i_instr_done) busy_q <= 1'b0;
      if (i_instr_done) o_mcycles <= (o_mcycles == 4'hA) ? 4'h1 : o_mcycles + 4'h1;
    end
  end
endmodule : clk_partner

//--- bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import clk_ctrl_pkg::*;
  localparam int SH = 20;
  logic i_core_clk, i_resetn, i_wr_en, i_rd_en, i_slow_xtal_in, i_stop_wake_n;
  logic i_irq_req, i_int_master_enable, i_time_base_irq_en;
  logic i_time_base_irq_clr, i_instr_start, o_main_tick, o_mcycle_end;
  logic o_instr_done, o_cpu_run, o_wdt_run, o_periph_clk_en, o_tbt_clk_en;
  logic o_fast_osc_on, o_slow_osc_on, o_slow_pins_are_port, o_main_from_slow;
  logic o_irq_accept, o_resume_next, o_time_base_irq, o_time_base_irq_take;
  logic [3:0]  i_addr, i_instr_mcycles;
  logic [7:0]  i_wr_data, o_rd_data;
  logic [20:0] o_divider;
  op_mode_t    o_mode;
  mc_state_t   o_mc_state;
  int err_total = 0, samples_checked = 0, cyc_q = 0;
  system_clock_mode_controller dut (.i_core_clk, .i_resetn, .i_addr,
    .i_wr_data, .i_wr_en, .i_rd_en, .i_slow_xtal_in, .i_stop_wake_n,
    .i_irq_req, .i_int_master_enable, .i_time_base_irq_en,
    .i_time_base_irq_clr, .i_instr_mcycles, .i_instr_start, .o_rd_data,
    .o_mode, .o_mc_state, .o_main_tick, .o_mcycle_end, .o_instr_done,
    .o_divider, .o_cpu_run, .o_wdt_run, .o_periph_clk_en, .o_tbt_clk_en,
    .o_fast_osc_on, .o_slow_osc_on, .o_slow_pins_are_port, .o_main_from_slow,
    .o_irq_accept, .o_resume_next, .o_time_base_irq, .o_time_base_irq_take);
  clk_partner #(.SLOW_HALF(SH)) u_cpu (.i_core_clk, .i_resetn,
    .i_cpu_run(o_cpu_run), .i_instr_done(o_instr_done),
    .o_slow_xtal(i_slow_xtal_in), .o_mcycles(i_instr_mcycles),
    .o_start(i_instr_start));
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 30000) begin
      err_total++;
      report_and_stop;
    end
  end
  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check
  task automatic tick;
    @(posedge i_core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_addr, i_wr_data, i_wr_en} <= {a, d, 1'b1};
    @(posedge i_core_clk);
    i_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    {i_addr, i_rd_en} <= {a, 1'b1};
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
    #1 check("rd", o_rd_data, e);
  endtask : rd
  task automatic wait_mode(input op_mode_t m, input int n);
    for (int k = 0; k < n && o_mode !== m; k++) tick;
    tick;
  endtask : wait_mode
  task automatic mc_len(input int e);
    int k;
    k = 0;
    wait_mode(o_mode, 0);
    while (o_mcycle_end !== 1'b1 && k < 999) begin
      tick;
      k++;
    end
    for (k = 1; k < 999; k++) begin
      tick;
      if (o_mcycle_end === 1'b1) break;
    end
    check("mcycle", k, e);
    check("state", o_mc_state, 2'h3);
  endtask : mc_len
  task automatic t_reset;
    check("mode", o_mode, RUN_SINGLE);
    check("clk", {o_cpu_run, o_periph_clk_en, o_main_from_slow}, 3'h6);
    rd(4'h1, 8'h80);
    rd(4'h2, 8'h00);
    rd(4'h7, 8'h00);
    mc_len(4);
  endtask : t_reset
  task automatic t_doze(input logic ime);
    @(posedge i_core_clk) i_int_master_enable <= ime;
    wr(4'h1, 8'h88);
    wait_mode(DOZE_SINGLE, 10);
    tick;
    check("doze", {o_mode, o_cpu_run}, {DOZE_SINGLE, 1'b0});
    @(posedge i_core_clk) i_irq_req <= 1'b1;
    @(posedge i_core_clk) i_irq_req <= 1'b0;
    #1 check("wake", {o_mode, o_irq_accept, o_resume_next}, {RUN_SINGLE, ime, !ime});
  endtask : t_doze
  task automatic t_deep(input logic en);
    wr(4'h2, {en, 7'h07});
    wr(4'h1, 8'h90);
    wait_mode(DEEP_DOZE_SINGLE, 10);
    tick;
    check("deep", {o_periph_clk_en, o_tbt_clk_en}, 2'h1);
    wait_mode(RUN_SINGLE, 2200);
    check("deep exit", o_mode, RUN_SINGLE);
    tick;
    check("pending", o_time_base_irq, en);
    @(posedge i_core_clk) {i_time_base_irq_en, i_int_master_enable} <= 2'h3;
    wait_mode(o_mode, 2);
    check("take", o_time_base_irq_take, en);
    wr(4'h2, 8'h00);
    {i_time_base_irq_clr, i_time_base_irq_en} <= 2'h2;
    @(posedge i_core_clk) i_time_base_irq_clr <= 1'b0;
    wait_mode(o_mode, 2);
    check("cleared", o_time_base_irq, 1'b0);
  endtask : t_deep
  task automatic t_mode(input logic [7:0] d, input op_mode_t m);
    wr(4'h1, d);
    wait_mode(m, 400);
    check("mode", o_mode, m);
  endtask : t_mode
  task automatic t_dual;
    t_mode(8'hC0, RUN_DUAL);
    repeat (8 * SH) tick;
    wr(4'h2, 8'h10);
    t_mode(8'hE0, SLOW_BOTH_OSC);
    mc_len(8 * SH);
    t_mode(8'h60, SLOW_OSC_ONLY);
    check("fast osc", o_fast_osc_on, 1'b0);
    t_mode(8'hE0, SLOW_BOTH_OSC);
    t_mode(8'hC0, RUN_DUAL);
    wr(4'h2, 8'h00);
    t_mode(8'h80, RUN_SINGLE);
  endtask : t_dual
  task automatic t_stop;
    int k;
    wr(4'h0, 8'h80);
    wait_mode(STOP_HALT, 10);
    tick;
    check("div", o_divider, 21'h0);
    @(posedge i_core_clk) i_stop_wake_n <= 1'b0;
    for (k = 0; k < 17000 && o_resume_next !== 1'b1; k++) tick;
    i_stop_wake_n <= 1'b1;
    check("warm-up", k >= 16384 && k < 16400, 1'b1);
    check("resume", o_mode, RUN_SINGLE);
  endtask : t_stop
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    {i_resetn, i_wr_en, i_rd_en, i_irq_req, i_int_master_enable} = 5'h0;
    {i_time_base_irq_en, i_time_base_irq_clr, i_addr, i_wr_data} = 14'h0;
    i_stop_wake_n = 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    tick;
    t_reset;
    t_doze(1'b0);
    t_doze(1'b1);
    t_deep(1'b1);
    t_deep(1'b0);
    t_dual;
    t_stop;
    report_and_stop;
  end
endmodule : tb_top
